/* inc/ctm_cfg.svh */
// Constants of the register-zero mode register decode block.
// Included by the package and the design; holds definitions only.
`ifndef CTM_CFG_SVH
`define CTM_CFG_SVH

// Mode-register bit positions
`define CTM_BIT_RSVD_TOP 21
`define CTM_BIT_SEL_HI 20
`define CTM_BIT_SEL_LO 18
`define CTM_BIT_RSVD_17 17
`define CTM_BIT_WR_HI 13
`define CTM_BIT_LAT_HI 12
`define CTM_BIT_WR_MID_HI 11
`define CTM_BIT_WR_MID_LO 9
`define CTM_BIT_DLL_RESET 8
`define CTM_BIT_TEST 7
`define CTM_BIT_LAT_MID_HI 6
`define CTM_BIT_LAT_MID_LO 4
`define CTM_BIT_ORDER 3
`define CTM_BIT_LAT_LO 2

// Register select codes
`define CTM_SEL_REG_ZERO 3'h0
`define CTM_SEL_FORBIDDEN 3'h7

// Burst size codes
`define CTM_BURST_FIXED_EIGHT 2'h0
`define CTM_BURST_ON_THE_FLY 2'h1
`define CTM_BURST_FIXED_CHOP 2'h2
`define CTM_BURST_RESERVED 2'h3

// Reset values of the held register and decoded fields
`define CTM_RESET_RAW 22'h000000
`define CTM_RESET_WR 5'h0a
`define CTM_RESET_RDPRE 4'h5
`define CTM_RESET_LAT 6'h09

// Feature update time after an accepted write, in clock cycles
`define CTM_MOD_CYCLES 5'h18

`endif

/* inc/ctm_pkg.sv */
// Types of the register-zero mode register decode block.
// Assumes ctm_cfg.svh sits on the include path.
`include "ctm_cfg.svh"

package ctm_pkg;

  // Command and address pins sampled on each rising clock edge
  typedef struct packed {
    logic cs_n;
    logic act_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic cke;
    logic [1:0] bg;
    logic [1:0] ba;
    logic a17;
    logic [13:0] addr;
  } ctm_pins_type;

  // Decoded register-zero settings
  typedef struct packed {
    logic [4:0] write_recovery_cycles;
    logic [3:0] read_to_precharge_cycles;
    logic [5:0] read_column_latency;
    logic burst_ordering_select;
    logic [1:0] burst_size_select;
    logic vendor_test_select;
  } ctm_fields_type;

endpackage

/* hw/ctm_mode_reg_zero.sv */
// Mode register set capture and register-zero decode of a DDR4 SDRAM.
// Assumes command pins synchronous to clock and a controller obeying
// the idle, termination and spacing conditions listed below.
// Summary of operation
// R01: Controller reprograms only when idle, banks precharged, CKE high.
// R02: Nominal termination on: controller keeps termination low until update.
// R03: With nominal termination off, termination pin level is free.
// R04: Some settings take longer than update time; own procedure governs.
// R05: Capture bits from bank group, bank, A17 and A13..A0 pins.
// R06: Controller drives row, column and write strobes low for command.
// R07: Controller writes zero to bits 21 and 17.
// R08: Bits 20:18 select target register; code seven is forbidden.
// R09: Decode write recovery and read-to-precharge from bits 13, 11:9.
// R10: Controller caps write recovery at 28 and read-to-precharge at 14.
// R11: Controller keeps vendor test bit 7 at zero.
// R12: Decode read latency from bits 12, 6:4, 2; low codes nine upward.
// R13: Decode upper read latency codes; code 10010 is undefined.
// R14: Under quarter-rate gear-down controller avoids odd latencies.
// R15: Bit 3 selects nibble-sequential or interleaved burst ordering.
// R16: Bits 1:0 select fixed eight, on-the-fly, fixed chop-four, reserved.
// R17: Only speed-bin settings exist; others are flagged unsupported.
// R18: DLL reset bit 8 starts a reset then clears itself.
// R19: Controller rewrites every field on each command.
// R20: Controller waits the update time before other commands.
// R21: Register zero loads only for select code zero.
`timescale 1ns/1ps
`include "ctm_cfg.svh"

module ctm_mode_reg_zero (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Command and address pins
  input wire ctm_pkg::ctm_pins_type pins,
  // Held register and decoded settings
  output logic [21:0] core_timing_mode_reg,
  output ctm_pkg::ctm_fields_type fields,
  // Command status
  output logic [2:0] mrs_target_q,
  output logic mrs_accept_q,
  output logic forbidden_code_q,
  output logic settings_unsupported_q,
  output logic dll_reset_pulse_q,
  output logic mod_busy_q
);
  import ctm_pkg::*;

  logic mrs_fire;
  logic [21:0] mr_bits;
  logic [3:0] wr_code;
  logic [4:0] lat_code;
  logic load_zero;
  logic [4:0] wr_next;
  logic [5:0] lat_next;
  logic unsupported_next;
  logic [4:0] mod_count_q;

  // Write-recovery code to clocks; zero marks a reserved code
  function automatic logic [4:0] wr_decode(input logic [3:0] code);
    logic [4:0] cyc;
    cyc = 5'h00;
    unique case (code)
      4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5: begin
        cyc = 5'h0a + {code[2:0], 1'b0} + {code[3], 1'b0};
      end
      4'h6: cyc = 5'h18;
      4'h7: cyc = 5'h16;
      4'h8: cyc = 5'h1a;
      4'h9: cyc = 5'h1c;
      default: cyc = 5'h00;
    endcase
    return cyc;
  endfunction

  // Read latency code to clocks; zero marks an undefined code
  function automatic logic [5:0] lat_decode(input logic [4:0] code);
    logic [5:0] cyc;
    cyc = 6'h00;
    unique case (code)
      5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07: begin
        cyc = 6'h09 + {3'h0, code[2:0]};
      end
      5'h08: cyc = 6'h12;
      5'h09: cyc = 6'h14;
      5'h0a: cyc = 6'h16;
      5'h0b: cyc = 6'h18;
      5'h0c: cyc = 6'h17;
      5'h0d: cyc = 6'h11;
      5'h0e: cyc = 6'h13;
      5'h0f: cyc = 6'h15;
      5'h10: cyc = 6'h19;
      5'h11: cyc = 6'h1a;
      5'h13: cyc = 6'h1c;
      5'h14: cyc = 6'h1d;
      5'h15: cyc = 6'h1e;
      5'h16: cyc = 6'h1f;
      5'h17: cyc = 6'h20;
      default: cyc = 6'h00;
    endcase
    return cyc;
  endfunction

  // Command decode, chip selected and all three strobes low
  assign mrs_fire = !pins.cs_n && pins.act_n && pins.cke &&
                    !pins.ras_n && !pins.cas_n && !pins.we_n; // see R06
  // Pin to bit mapping; bits 16:14 have no pin
  assign mr_bits = {pins.bg, pins.ba, pins.a17, 3'h0, pins.addr}; // see R05
  assign load_zero = mrs_fire &&
    (mr_bits[`CTM_BIT_SEL_HI:`CTM_BIT_SEL_LO] == `CTM_SEL_REG_ZERO); // see R21
  assign wr_code = {mr_bits[`CTM_BIT_WR_HI],
                    mr_bits[`CTM_BIT_WR_MID_HI:`CTM_BIT_WR_MID_LO]};
  assign lat_code = {mr_bits[`CTM_BIT_LAT_HI],
                     mr_bits[`CTM_BIT_LAT_MID_HI:`CTM_BIT_LAT_MID_LO],
                     mr_bits[`CTM_BIT_LAT_LO]};
  assign wr_next = wr_decode(wr_code); // see R09
  assign lat_next = lat_decode(lat_code); // see R12 see R13
  // Settings this die lacks: reserved, undefined or test codes
  assign unsupported_next = (wr_next == 5'h00) || (lat_next == 6'h00) ||
    (mr_bits[1:0] == `CTM_BURST_RESERVED) || mr_bits[`CTM_BIT_TEST] ||
    mr_bits[`CTM_BIT_RSVD_TOP] || mr_bits[`CTM_BIT_RSVD_17]; // see R17

  // Held register zero image
  always_ff @(posedge clock) begin
    if (reset) begin
      core_timing_mode_reg <= `CTM_RESET_RAW;
    end else if (load_zero) begin
      core_timing_mode_reg <= mr_bits; // see R05 see R21
    end
  end

  // Decoded fields; reserved codes keep the previous timing
  always_ff @(posedge clock) begin
    if (reset) begin
      fields.write_recovery_cycles <= `CTM_RESET_WR;
      fields.read_to_precharge_cycles <= `CTM_RESET_RDPRE;
      fields.read_column_latency <= `CTM_RESET_LAT;
      fields.burst_ordering_select <= 1'b0;
      fields.burst_size_select <= `CTM_BURST_FIXED_EIGHT;
      fields.vendor_test_select <= 1'b0;
    end else if (load_zero) begin
      if (wr_next != 5'h00) begin
        fields.write_recovery_cycles <= wr_next; // see R09
        fields.read_to_precharge_cycles <= wr_next[4:1]; // see R09
      end
      if (lat_next != 6'h00) begin
        fields.read_column_latency <= lat_next; // see R12 see R13
      end
      fields.burst_ordering_select <= mr_bits[`CTM_BIT_ORDER]; // see R15
      fields.burst_size_select <= mr_bits[1:0]; // see R16
      fields.vendor_test_select <= mr_bits[`CTM_BIT_TEST];
    end
  end

  // Command status and target register
  always_ff @(posedge clock) begin
    if (reset) begin
      mrs_accept_q <= 1'b0;
      mrs_target_q <= 3'h0;
      forbidden_code_q <= 1'b0;
      settings_unsupported_q <= 1'b0;
    end else begin
      mrs_accept_q <= mrs_fire;
      if (mrs_fire) begin
        mrs_target_q <= mr_bits[`CTM_BIT_SEL_HI:`CTM_BIT_SEL_LO]; // see R08
        forbidden_code_q <= (mr_bits[`CTM_BIT_SEL_HI:`CTM_BIT_SEL_LO] ==
                             `CTM_SEL_FORBIDDEN); // see R08
      end
      if (load_zero) begin
        settings_unsupported_q <= unsupported_next; // see R17
      end
    end
  end

  // Self-clearing DLL reset request, one cycle wide
  always_ff @(posedge clock) begin
    if (reset) begin
      dll_reset_pulse_q <= 1'b0;
    end else begin
      dll_reset_pulse_q <= load_zero && mr_bits[`CTM_BIT_DLL_RESET]; // see R18
    end
  end

  // Feature update window; a DLL reset write follows its own procedure
  always_ff @(posedge clock) begin
    if (reset) begin
      mod_count_q <= 5'h00;
      mod_busy_q <= 1'b0;
    end else if (load_zero && !mr_bits[`CTM_BIT_DLL_RESET]) begin
      mod_count_q <= `CTM_MOD_CYCLES; // see R04
      mod_busy_q <= 1'b1;
    end else begin
      mod_count_q <= (mod_count_q != 5'h00) ? mod_count_q - 5'h01 : 5'h00;
      mod_busy_q <= (mod_count_q > 5'h01);
    end
  end

  // Checks on the design's own behaviour
  sequence s_zero_write;
    load_zero;
  endsequence

  sequence s_dll_write;
    load_zero && mr_bits[`CTM_BIT_DLL_RESET];
  endsequence

  sequence s_dll_pulse_then_clear;
    dll_reset_pulse_q ##1 !dll_reset_pulse_q;
  endsequence

  AST_CAPTURE: assert property (@(posedge clock) disable iff (reset) // see R05
    s_zero_write |=> core_timing_mode_reg == $past(mr_bits))
    else $error("register zero did not capture pins");

  AST_HOLD_OTHER: assert property ( // see R21
    @(posedge clock) disable iff (reset)
    mrs_fire && !load_zero |=> $stable(core_timing_mode_reg))
    else $error("register zero changed on other target");

  AST_TARGET: assert property (@(posedge clock) disable iff (reset) // see R08
    mrs_fire |=> mrs_target_q == $past(mr_bits[20:18]) &&
      forbidden_code_q == ($past(mr_bits[20:18]) == 3'h7))
    else $error("target select decode wrong");

  AST_WR_LOW: assert property (@(posedge clock) disable iff (reset) // see R09
    s_zero_write ##0 (wr_code < 4'h6) |=>
      fields.write_recovery_cycles == 5'h0a + 5'($past(wr_code)) * 5'h02 &&
      fields.read_to_precharge_cycles == 4'h5 + $past(wr_code))
    else $error("write recovery decode wrong");

  AST_WR_HIGH: assert property (@(posedge clock) disable iff (reset) // see R09
    s_zero_write ##0 (wr_code == 4'h6) |=>
      fields.write_recovery_cycles == 5'h18 &&
      fields.read_to_precharge_cycles == 4'hc)
    else $error("write recovery code six wrong");

  AST_LAT_LOW: assert property (@(posedge clock) disable iff (reset) // see R12
    s_zero_write ##0 (lat_code < 5'h08) |=>
      fields.read_column_latency == 6'h09 + 6'($past(lat_code)))
    else $error("read latency decode wrong");

  AST_LAT_GAP: assert property (@(posedge clock) disable iff (reset) // see R13
    s_zero_write ##0 (lat_code == 5'h12) |=>
      settings_unsupported_q && $stable(fields.read_column_latency))
    else $error("undefined latency code accepted");

  AST_BURST: assert property ( // see R15 see R16
    @(posedge clock) disable iff (reset)
    s_zero_write |=> fields.burst_ordering_select == $past(mr_bits[3]) &&
      fields.burst_size_select == $past(mr_bits[1:0]))
    else $error("burst settings not taken");

  AST_DLL: assert property (@(posedge clock) disable iff (reset) // see R18
    s_dll_write |=> s_dll_pulse_then_clear)
    else $error("DLL reset did not self-clear");

  AST_MOD: assert property (@(posedge clock) disable iff (reset) // see R04
    s_zero_write ##0 !mr_bits[8] |=> mod_busy_q[*8])
    else $error("update window too short");

endmodule

/* testbench/ctm_ctrl_model.sv */
// Controller model driving mode register set commands at falling edges.
// Assumes the bench owns the clock and calls mrs for each command.
`timescale 1ns/1ps

module ctm_ctrl_model (
  // Clock
  input wire logic clock,
  // Command pins toward the device
  output ctm_pkg::ctm_pins_type pins
);
  import ctm_pkg::*;

  // Idle deselect with clock enable high from time zero
  initial begin
    pins = '0;
    pins.cs_n = 1'b1;
    pins.act_n = 1'b1;
    pins.cke = 1'b1;
  end

  // Only mode writes and deselects are issued
  // One command cycle, then deselect with address lines turned over
  task automatic mrs(input logic [21:0] v);
    @(negedge clock);
    pins.cs_n = 1'b0;
    {pins.ras_n, pins.cas_n, pins.we_n} = 3'h0;
    {pins.bg, pins.ba, pins.a17, pins.addr} = {v[21:17], v[13:0]};
    @(negedge clock);
    pins.cs_n = 1'b1;
    {pins.ras_n, pins.cas_n, pins.we_n} = 3'h7;
    {pins.bg, pins.ba, pins.a17, pins.addr} = ~{v[21:17], v[13:0]};
  endtask
endmodule

/* testbench/test_ctm_mode_reg_zero.sv */
// Self-checking bench of the register-zero mode register decode.
// Assumes the controller model drives every command pin.
`timescale 1ns/1ps
`include "ctm_cfg.svh"

module test_ctm_mode_reg_zero;
  import ctm_pkg::*;

  logic clock = 1'b0;
  logic reset = 1'b1;
  ctm_pins_type pins;
  logic [21:0] core_timing_mode_reg;
  ctm_fields_type fields;
  logic [2:0] mrs_target_q;
  logic mrs_accept_q, forbidden_code_q, settings_unsupported_q;
  logic dll_reset_pulse_q, mod_busy_q;
  logic [21:0] v;
  int n;
  int err_total = 0;
  int n_checks = 0;
  // Rows: index is the code, value the clocks it should decode to
  logic [4:0] wr_tab [10] = '{5'h0a, 5'h0c, 5'h0e, 5'h10, 5'h12, 5'h14,
    5'h18, 5'h16, 5'h1a, 5'h1c};
  logic [5:0] lat_tab [24] = '{6'h09, 6'h0a, 6'h0b, 6'h0c, 6'h0d, 6'h0e,
    6'h0f, 6'h10, 6'h12, 6'h14, 6'h16, 6'h18, 6'h17, 6'h11, 6'h13, 6'h15,
    6'h19, 6'h1a, 6'h00, 6'h1c, 6'h1d, 6'h1e, 6'h1f, 6'h20};
  // Writes that must be flagged: burst 11, test, bit 21, bit 17
  logic [21:0] bad [4] = '{22'h000003, 22'h000080, 22'h200000, 22'h020000};

  // Clock
  initial begin
    forever #2.5 clock = ~clock;
  end

  ctm_mode_reg_zero DUT (
    .clock(clock),
    .reset(reset),
    .pins(pins),
    .core_timing_mode_reg(core_timing_mode_reg),
    .fields(fields),
    .mrs_target_q(mrs_target_q),
    .mrs_accept_q(mrs_accept_q),
    .forbidden_code_q(forbidden_code_q),
    .settings_unsupported_q(settings_unsupported_q),
    .dll_reset_pulse_q(dll_reset_pulse_q),
    .mod_busy_q(mod_busy_q)
  );

  ctm_ctrl_model ctrl (
    .clock(clock),
    .pins(pins)
  );

  // Comparison and mismatch report
  task automatic chk(input string name, input logic [21:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  // Verdict and end of run
  task automatic give_verdict;
    if (err_total == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Places the recovery and latency codes on their scattered bits
  // Bits 21, 17 and test bit 7 stay zero
  function automatic logic [21:0] enc(input logic [3:0] w,
                                      input logic [4:0] c);
    enc = {8'h00, w[3], c[4], w[2:0], 2'h0, c[3:1], 1'h0, c[0], 2'h0};
  endfunction

  // Held register and every decoded field
  task automatic chk_all(input logic [21:0] r, input logic [4:0] wr,
                         input logic [5:0] lat);
    chk("reg", core_timing_mode_reg, r);
    chk("wr", fields.write_recovery_cycles, wr);
    chk("rdpre", fields.read_to_precharge_cycles, wr >> 1);
    chk("latency", fields.read_column_latency, lat);
    chk("test", fields.vendor_test_select, r[7]);
    chk("order", fields.burst_ordering_select, r[3]);
    chk("size", fields.burst_size_select, r[1:0]);
  endtask

  // Main sequence
  initial begin
    repeat (20) @(negedge clock);
    reset = 1'b0;
    chk_all(22'h0, 5'h0a, 6'h09);
    chk("status", {mrs_accept_q, mod_busy_q, dll_reset_pulse_q},
        3'h0);
    // Table rows: every defined latency code and recovery code
    // Gear-down is off and recovery stays within 28
    for (int i = 0; i < 24; i++) begin
      if (i != 18) begin
        v = enc(4'(i % 10), 5'(i)) | 22'(i % 3) | (22'(i % 2) << 3);
        ctrl.mrs(v);
        chk("accept", mrs_accept_q, 1'b1);
        chk("unsup", settings_unsupported_q, 1'b0);
        chk_all(v, wr_tab[i % 10], lat_tab[i]);
      end
    end
    // Other targets and the forbidden select leave register zero alone
    for (int s = 1; s < 8; s++) begin
      ctrl.mrs({1'b0, 3'(s), 18'h03fff});
      chk("target", mrs_target_q, 22'(s));
      chk("forbid", forbidden_code_q, s == 7);
      chk_all(v, wr_tab[3], lat_tab[23]);
    end
    // Reserved recovery and undefined latency keep the old decode
    ctrl.mrs(enc(4'ha, 5'h12));
    chk("unsup", settings_unsupported_q, 1'b1);
    chk("wr", fields.write_recovery_cycles, wr_tab[3]);
    chk("latency", fields.read_column_latency, lat_tab[23]);
    for (int k = 0; k < 4; k++) begin
      ctrl.mrs(bad[k]);
      chk("unsup", settings_unsupported_q, 1'b1);
      chk("test", fields.vendor_test_select, bad[k][7]);
    end
    // DLL reset pulses once and opens no update window
    repeat (30) @(negedge clock);
    ctrl.mrs(22'h000104);
    chk("dll", dll_reset_pulse_q, 1'b1);
    chk("busy", mod_busy_q, 1'b0);
    chk("unsup", settings_unsupported_q, 1'b0);
    chk("latency", fields.read_column_latency, 6'h0a);
    @(negedge clock);
    chk("dll", dll_reset_pulse_q, 1'b0);
    chk("accept", mrs_accept_q, 1'b0);
    // A plain write holds the update window for the set count
    ctrl.mrs(22'h000000);
    n = 0;
    while (mod_busy_q === 1'b1 && n < 100) begin
      @(negedge clock);
      n++;
    end
    chk("window", 22'(n), 22'(`CTM_MOD_CYCLES));
    // Reset in mid-run restores the reset decode
    ctrl.mrs(enc(4'h9, 5'h17));
    reset = 1'b1;
    @(negedge clock);
    reset = 1'b0;
    chk_all(22'h0, 5'h0a, 6'h09);
    give_verdict;
  end

  // Watchdog well beyond the expected run
  initial begin
    #50000;
    err_total++;
    give_verdict;
  end
endmodule
